// >>> pbcs_defines.vh
// Purpose: Constants for the PHY basic control and status register block.
// Assumes: 16-bit management registers, frames carried on MDC/MDIO.
// Notes:   Offsets, bit positions, reset values and frame codes only.
`ifndef PBCS_DEFINES_VH
`define PBCS_DEFINES_VH

// Register addresses on the management interface
`define PBCS_REG_CTRL 5'h00
`define PBCS_REG_STAT 5'h01

// Control register bit positions
`define PBCS_CTRL_SPEED 13
`define PBCS_CTRL_AN_EN 12
`define PBCS_CTRL_PDOWN 11
`define PBCS_CTRL_ISOLATE 10
`define PBCS_CTRL_RESTART 9
`define PBCS_CTRL_DUPLEX 8
`define PBCS_CTRL_COLTEST 7

// Control register reset values
`define PBCS_RST_SPEED 1'h1
`define PBCS_RST_AN_EN 1'h1
`define PBCS_RST_PDOWN 1'h0
`define PBCS_RST_ISOLATE 1'h0
`define PBCS_RST_DUPLEX 1'h1
`define PBCS_RST_COLTEST 1'h0

// Status register bit positions of the live bits
`define PBCS_STAT_AN_DONE 5
`define PBCS_STAT_FAULT 4
`define PBCS_STAT_LINK 2
`define PBCS_STAT_JABBER 1

// Fixed status bits: 14..11 abilities, 6 preamble, 3 negotiation, 0 extended
`define PBCS_STAT_FIXED 16'h7849

// Management frame fields
`define PBCS_OP_READ 2'h2
`define PBCS_OP_WRITE 2'h1
`define PBCS_HDR_LAST 5'h0B
`define PBCS_DATA_LAST 5'h0F

`endif

// >>> pbcs_sync.v
// Purpose: Two-stage synchroniser for levels entering the clk_in domain.
// Assumes: Inputs are slow enough that each level is seen for a few cycles.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module pbcs_sync #(
    parameter WIDTH = 2
) (
    input wire clk_in, // System clock
    input wire rst_n_in, // Asynchronous reset, active low
    input wire [WIDTH-1:0] async_in, // Levels from outside the domain
    output wire [WIDTH-1:0] sync_out // Synchronised levels
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // Two flops; metastability settles in the first
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

`default_nettype wire

// >>> pbcs_top.v
// Purpose: PHY basic control and status registers behind an MDC/MDIO port.
// Assumes: clk_in at 100 MHz, MDC far slower; PHY core signals on clk_in.
// Notes:   MDC is sampled, not used as a clock; MDIO output changes after
//          each sampled MDC rising edge.
// Behaviour
// - Control bit 11 powers down; management stays alive
// - MII outputs held quiet during power-down
// - Restart bit self-clears once negotiation starts
// - Restart ignored while negotiation is disabled
// - Clearing restart never aborts running negotiation
// - Duplex bit manual only when negotiation off
// - Collision test echoes TX_EN onto COL
// - Control bits 6..0 read zero, ignore writes
// - Preamble-less management frames are accepted
// - Status bit 5 shows negotiation complete
// - Remote fault latches, cleared by status read
// - Link bit latches low until read
// - Jabber latches high, detected only at 10Mbps
// - Negotiation enable; duplex, speed show results
`include "pbcs_defines.vh"
`default_nettype none

module pbcs_top (
    input wire clk_in, // System clock, 100 MHz
    input wire rst_n_in, // Chip reset, asynchronous, active low
    input wire mdc_in, // Management clock pin
    input wire mdio_in, // Management data pin, input side
    output wire mdio_out, // Management data pin, output side
    output wire mdio_oe_out, // Management data pin, drive enable
    input wire [4:0] phy_addr_in, // This PHY's management address
    input wire link_ok_in, // Core: valid 10/100 link present
    input wire jabber_in, // Core: jabber condition present
    input wire partner_fault_flag_in, // Partner ability register fault bit
    input wire an_done_in, // Core: negotiation complete
    input wire an_started_in, // Core: pulse, new negotiation started
    input wire neg_duplex_in, // Core: negotiated full duplex
    input wire neg_speed_in, // Core: negotiated 100Mbps
    input wire mii_tx_en_in, // Internal MII transmit enable
    input wire mii_col_in, // Core collision indication
    input wire mii_rx_dv_in, // Core receive data valid
    input wire [3:0] mii_rxd_in, // Core receive data
    output wire mii_col_out, // Internal MII collision
    output wire mii_rx_dv_out, // Internal MII receive data valid
    output wire [3:0] mii_rxd_out, // Internal MII receive data
    output wire power_down_out, // Core power-down request
    output wire isolate_out, // Core isolate request
    output wire an_enable_out, // Negotiation enable
    output wire an_restart_out, // Negotiation restart request, level
    output wire duplex_out, // Duplex in effect, 1 = full
    output wire speed_out // Speed in effect, 1 = 100Mbps
);

    localparam S_IDLE = 3'h0;
    localparam S_ST = 3'h1;
    localparam S_HDR = 3'h2;
    localparam S_TA = 3'h3;
    localparam S_DATA = 3'h4;

    wire [1:0] pin_s;
    wire mdc_s;
    wire mdio_s;
    reg mdc_d_r;
    wire mdc_rise;

    reg [2:0] st_r;
    reg [4:0] cnt_r;
    reg [11:0] hdr_r;
    reg [15:0] sh_r;
    reg rd_r;
    reg wr_r;
    reg [4:0] reg_r;
    reg mdio_out_r;
    reg mdio_oe_r;

    reg speed_r;
    reg an_en_r;
    reg pd_r;
    reg iso_r;
    reg restart_r;
    reg dup_r;
    reg coltest_r;
    reg fault_r;
    reg link_r;
    reg jab_r;

    reg col_r;
    reg rx_dv_r;
    reg [3:0] rxd_r;

    wire [11:0] hdr_nxt;
    wire hdr_match;
    wire do_read;
    wire do_write;
    wire stat_clr;
    wire [15:0] wdata;
    wire dup_eff;
    wire speed_eff;
    wire [15:0] ctrl_val;
    wire [15:0] stat_val;
    reg [15:0] rdata;

    // Both pins pass two flops; MDC edges are found on the synced copy
    pbcs_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({mdc_in, mdio_in}),
        .sync_out(pin_s)
    );

    assign mdc_s = pin_s[1];
    assign mdio_s = pin_s[0];
    assign mdc_rise = mdc_s & ~mdc_d_r;

    // Previous MDC level for edge detection
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mdc_d_r <= 1'b0;
        end else begin
            mdc_d_r <= mdc_s;
        end
    end

    // Frame header decode at the last address bit
    assign hdr_nxt = {hdr_r[10:0], mdio_s};
    assign hdr_match = mdc_rise && (st_r == S_HDR) && (cnt_r == `PBCS_HDR_LAST)
        && (hdr_nxt[9:5] == phy_addr_in);
    assign do_read = hdr_match && (hdr_nxt[11:10] == `PBCS_OP_READ);
    assign stat_clr = do_read && (hdr_nxt[4:0] == `PBCS_REG_STAT);
    assign wdata = {sh_r[14:0], mdio_s};
    assign do_write = mdc_rise && (st_r == S_DATA) && (cnt_r == `PBCS_DATA_LAST)
        && wr_r && (reg_r == `PBCS_REG_CTRL);

    assign dup_eff = an_en_r ? neg_duplex_in : dup_r;
    assign speed_eff = an_en_r ? neg_speed_in : speed_r;

    assign ctrl_val = {2'h0, speed_eff, an_en_r, pd_r, iso_r, restart_r, dup_eff,
        coltest_r, 7'h00};

    // Fixed abilities merged with live flags
    assign stat_val = `PBCS_STAT_FIXED
        | ({15'h0000, an_done_in} << `PBCS_STAT_AN_DONE)
        | ({15'h0000, fault_r} << `PBCS_STAT_FAULT)
        | ({15'h0000, link_r} << `PBCS_STAT_LINK)
        | ({15'h0000, jab_r} << `PBCS_STAT_JABBER);

    // Read data selection; other addresses answer zero
    always @* begin
        case (hdr_nxt[4:0])
            `PBCS_REG_CTRL: rdata = ctrl_val;
            `PBCS_REG_STAT: rdata = stat_val;
            default: rdata = 16'h0000;
        endcase
    end

    // Management frame engine, one step per MDC rising edge
    // Start bits accepted with or without preamble
    // Frame engine never gated by power-down
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= S_IDLE;
            cnt_r <= 5'h00;
            hdr_r <= 12'h000;
            sh_r <= 16'h0000;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            reg_r <= 5'h00;
            mdio_out_r <= 1'b0;
            mdio_oe_r <= 1'b0;
        end else if (mdc_rise) begin
            case (st_r)
                S_IDLE: begin
                    mdio_oe_r <= 1'b0;
                    if (!mdio_s) begin
                        st_r <= S_ST;
                    end
                end
                S_ST: begin
                    cnt_r <= 5'h00;
                    st_r <= mdio_s ? S_HDR : S_IDLE;
                end
                S_HDR: begin
                    hdr_r <= hdr_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `PBCS_HDR_LAST) begin
                        cnt_r <= 5'h00;
                        reg_r <= hdr_nxt[4:0];
                        rd_r <= do_read;
                        wr_r <= hdr_match && (hdr_nxt[11:10] == `PBCS_OP_WRITE);
                        sh_r <= rdata;
                        if ((hdr_nxt[11:10] == `PBCS_OP_READ)
                            || (hdr_nxt[11:10] == `PBCS_OP_WRITE)) begin
                            st_r <= S_TA;
                        end else begin
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_TA: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        // Turnaround zero driven only for our own reads
                        mdio_oe_r <= rd_r;
                        mdio_out_r <= 1'b0;
                    end else begin
                        cnt_r <= 5'h00;
                        st_r <= S_DATA;
                        if (rd_r) begin
                            mdio_out_r <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end
                    end
                end
                S_DATA: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (rd_r) begin
                        mdio_out_r <= sh_r[15];
                        sh_r <= {sh_r[14:0], 1'b0};
                    end else begin
                        sh_r <= wdata;
                    end
                    if (cnt_r == `PBCS_DATA_LAST) begin
                        mdio_oe_r <= 1'b0;
                        rd_r <= 1'b0;
                        wr_r <= 1'b0;
                        st_r <= S_IDLE;
                    end
                end
                default: begin
                    mdio_oe_r <= 1'b0;
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    // Control register; writes land on the last data bit
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            speed_r <= `PBCS_RST_SPEED;
            an_en_r <= `PBCS_RST_AN_EN;
            pd_r <= `PBCS_RST_PDOWN;
            iso_r <= `PBCS_RST_ISOLATE;
            dup_r <= `PBCS_RST_DUPLEX;
            coltest_r <= `PBCS_RST_COLTEST;
        end else if (do_write) begin
            an_en_r <= wdata[`PBCS_CTRL_AN_EN];
            pd_r <= wdata[`PBCS_CTRL_PDOWN];
            iso_r <= wdata[`PBCS_CTRL_ISOLATE];
            coltest_r <= wdata[`PBCS_CTRL_COLTEST];
            if (!an_en_r) begin
                dup_r <= wdata[`PBCS_CTRL_DUPLEX];
                speed_r <= wdata[`PBCS_CTRL_SPEED];
            end
        end
    end

    // Restart request: a write of one wins over the core's start pulse
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            restart_r <= 1'b0;
        end else if (do_write && wdata[`PBCS_CTRL_AN_EN] && wdata[`PBCS_CTRL_RESTART]) begin
            restart_r <= 1'b1;
        end else if (do_write || !an_en_r) begin
            restart_r <= 1'b0;
        end else if (an_started_in) begin
            restart_r <= 1'b0;
        end
    end

    // Latched status flags; the snapshot in sh_r was taken before clearing
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_r <= 1'b0;
            link_r <= 1'b0;
            jab_r <= 1'b0;
        end else begin
            // Fault latch, cleared by status read
            // Present fault sets it again in the same cycle
            fault_r <= (fault_r & ~stat_clr) | partner_fault_flag_in;
            link_r <= stat_clr ? link_ok_in : (link_r & link_ok_in);
            jab_r <= (jab_r & ~stat_clr) | (jabber_in & ~speed_eff);
        end
    end

    // MII outputs registered so power-down entry cannot glitch them
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            col_r <= 1'b0;
            rx_dv_r <= 1'b0;
            rxd_r <= 4'h0;
        end else if (pd_r) begin
            col_r <= 1'b0;
            rx_dv_r <= 1'b0;
            rxd_r <= 4'h0;
        end else begin
            col_r <= coltest_r ? mii_tx_en_in : mii_col_in;
            rx_dv_r <= mii_rx_dv_in;
            rxd_r <= mii_rxd_in;
        end
    end

    assign mdio_out = mdio_out_r;
    assign mdio_oe_out = mdio_oe_r;
    assign mii_col_out = col_r;
    assign mii_rx_dv_out = rx_dv_r;
    assign mii_rxd_out = rxd_r;
    assign power_down_out = pd_r;
    assign isolate_out = iso_r;
    assign an_enable_out = an_en_r;
    assign an_restart_out = restart_r;
    assign duplex_out = dup_eff;
    assign speed_out = speed_eff;

endmodule

`default_nettype wire

// >>> pbcs_sta_model.sv
// Purpose: Station management model sending MDC/MDIO frames.
// Assumes: MDC period 80 ns; pins move on clk_in falls.
// Notes: MDC rests low between frames.
`default_nettype none
module pbcs_sta_model (
    input wire logic clk_in, // Bench clock
    input wire logic mdio_in, // Resolved line
    output logic mdc_out, // Management clock
    output logic mdio_out, // Drive value
    output logic mdio_oe_out // Drive enable
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: clock low, line released
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_out = 1'b0;
    end
    // One MDC period; sampled just before the rise, where read data is settled
    task automatic cyc1(input logic oe, input logic v, output logic s);
        mdio_oe_out = oe;
        mdio_out = v;
        repeat (4) @(negedge clk_in);
        s = mdio_in;
        mdc_out = 1'b1;
        repeat (4) @(negedge clk_in);
        mdc_out = 1'b0;
    endtask
    // Whole frame; released from turnaround on for reads
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, input logic pre, output logic [15:0] rd);
        logic [31:0] f;
        logic s;
        wd[10] = 1'b0;
        f = {2'b01, op, pa, ra, 2'b10, wd};
        @(negedge clk_in);
        repeat (pre ? 32 : 0) cyc1(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            cyc1(op == 2'h1 || i > 17, f[i], s);
            if (i < 16) rd[i] = s;
        end
        mdio_oe_out = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// >>> pbcs_top_properties.sv
// Purpose: Port-level checks of the PHY control and status block.
// Assumes: Only top-level ports are visible.
// Notes: MII outputs lag their inputs by one clock.
`default_nettype none
module pbcs_top_properties (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic mii_tx_en_in,
    input wire logic mii_col_in,
    input wire logic mii_rx_dv_in,
    input wire logic mii_col_out,
    input wire logic mii_rx_dv_out,
    input wire logic power_down_out,
    input wire logic isolate_out,
    input wire logic an_enable_out,
    input wire logic an_restart_out,
    input wire logic an_started_in,
    input wire logic duplex_out,
    input wire logic speed_out,
    input wire logic neg_duplex_in,
    input wire logic neg_speed_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Power-down silences the MII
    property p_pd_quiet;
        power_down_out && $past(power_down_out) |-> !mii_col_out && !mii_rx_dv_out;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("MII active in power-down");
    // Receive path passes one clock later when awake
    property p_rx_pass;
        $past(rst_n_in) && !$past(power_down_out) |-> mii_rx_dv_out == $past(mii_rx_dv_in);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("rx valid not passed");
    // Collision equals core input whenever it agrees with transmit enable
    property p_col;
        $past(rst_n_in) && !$past(power_down_out) && ($past(mii_tx_en_in) == $past(mii_col_in))
            |-> mii_col_out == $past(mii_col_in);
    endproperty
    a_col: assert property (p_col) else $error("collision output wrong");
    property p_dup_neg;
        an_enable_out |-> duplex_out == neg_duplex_in;
    endproperty
    a_dup_neg: assert property (p_dup_neg) else $error("duplex not negotiated");
    property p_spd_neg;
        an_enable_out |-> speed_out == neg_speed_in;
    endproperty
    a_spd_neg: assert property (p_spd_neg) else $error("speed not negotiated");
    property p_rs_off;
        !an_enable_out |-> !an_restart_out;
    endproperty
    a_rs_off: assert property (p_rs_off) else $error("restart while disabled");
    // Restart request drops once the core starts
    property p_rs_clr;
        an_restart_out && an_started_in |=> !an_restart_out;
    endproperty
    a_rs_clr: assert property (p_rs_clr) else $error("restart not cleared");
    property p_iso;
        !isolate_out ##1 !isolate_out;
    endproperty
    a_iso: assert property (p_iso) else $error("isolate raised");
endmodule
bind pbcs_top pbcs_top_properties chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .mii_tx_en_in(mii_tx_en_in), .mii_col_in(mii_col_in), .mii_rx_dv_in(mii_rx_dv_in),
    .mii_col_out(mii_col_out), .mii_rx_dv_out(mii_rx_dv_out), .isolate_out(isolate_out),
    .power_down_out(power_down_out), .an_enable_out(an_enable_out),
    .an_restart_out(an_restart_out), .an_started_in(an_started_in), .duplex_out(duplex_out),
    .speed_out(speed_out), .neg_duplex_in(neg_duplex_in), .neg_speed_in(neg_speed_in));
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the PHY control/status registers.
// Assumes: PHY address 01; MDIO pulled up when released.
// Notes: Registers reached only through management frames.
`include "pbcs_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic link = 1'b1, jab = 1'b0, flt = 1'b0, done = 1'b0, start = 1'b0;
    logic ndup = 1'b1, nspd = 1'b1, tx = 1'b0, col = 1'b0, rdv = 1'b0;
    logic [3:0] rxd = 4'h5;
    logic [15:0] rv;
    wire mdc, s_do, s_oe, d_do, d_oe, col_o, rdv_o, pd_o, iso_o, ane_o, rs_o, dup_o, spd_o;
    wire [3:0] rxd_o;
    wire mdio = d_oe ? d_do : (s_oe ? s_do : 1'b1);
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    pbcs_sta_model sm_u (.clk_in(clk_in), .mdio_in(mdio), .mdc_out(mdc), .mdio_out(s_do),
        .mdio_oe_out(s_oe));
    pbcs_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .mdc_in(mdc), .mdio_in(mdio),
        .mdio_out(d_do), .mdio_oe_out(d_oe), .phy_addr_in(5'h01), .link_ok_in(link),
        .jabber_in(jab), .partner_fault_flag_in(flt), .an_done_in(done),
        .an_started_in(start), .neg_duplex_in(ndup), .neg_speed_in(nspd), .mii_tx_en_in(tx),
        .mii_col_in(col), .mii_rx_dv_in(rdv), .mii_rxd_in(rxd), .mii_col_out(col_o),
        .mii_rx_dv_out(rdv_o), .mii_rxd_out(rxd_o), .power_down_out(pd_o),
        .isolate_out(iso_o), .an_enable_out(ane_o), .an_restart_out(rs_o),
        .duplex_out(dup_o), .speed_out(spd_o));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Hang guard; the run needs about 12000 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input logic pre);
        sm_u.frame(`PBCS_OP_READ, 5'h01, ra, 16'h0000, pre, rv);
        chk(rv, exp);
    endtask
    task automatic wr(input logic [15:0] wd);
        sm_u.frame(`PBCS_OP_WRITE, 5'h01, `PBCS_REG_CTRL, wd, 1'b1, rv);
    endtask
    // Main sequence; inputs move on falling edges
    initial begin
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rd(`PBCS_REG_CTRL, 16'h3100, 1'b1);
        rd(`PBCS_REG_STAT, 16'h7849, 1'b0);
        rd(`PBCS_REG_STAT, 16'h784D, 1'b0);
        link = 1'b0;
        repeat (3) @(negedge clk_in);
        link = 1'b1;
        rd(`PBCS_REG_STAT, 16'h7849, 1'b0);
        rd(`PBCS_REG_STAT, 16'h784D, 1'b0);
        // Jabber ignored at 100, latched at 10
        jab = 1'b1;
        repeat (2) @(negedge clk_in);
        jab = 1'b0;
        rd(`PBCS_REG_STAT, 16'h784D, 1'b0);
        nspd = 1'b0;
        jab = 1'b1;
        repeat (2) @(negedge clk_in);
        jab = 1'b0;
        rd(`PBCS_REG_STAT, 16'h784F, 1'b0);
        rd(`PBCS_REG_STAT, 16'h784D, 1'b0);
        // Fault still present when read sets the flag again
        done = 1'b1;
        flt = 1'b1;
        rd(`PBCS_REG_STAT, 16'h787D, 1'b1);
        flt = 1'b0;
        // Frame for another address: line stays released, flag kept
        sm_u.frame(`PBCS_OP_READ, 5'h02, `PBCS_REG_STAT, 16'h0000, 1'b0, rv);
        chk(rv, 16'hFFFF);
        rd(`PBCS_REG_STAT, 16'h787D, 1'b1);
        rd(`PBCS_REG_STAT, 16'h786D, 1'b1);
        done = 1'b0;
        wr(16'h1200);
        chk({15'h0, rs_o}, 16'h0001);
        rd(`PBCS_REG_CTRL, 16'h1300, 1'b1);
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        rd(`PBCS_REG_CTRL, 16'h1100, 1'b1);
        // Manual duplex and speed hold reset values until written with negotiation off
        wr(16'h0000);
        rd(`PBCS_REG_CTRL, 16'h2100, 1'b1);
        chk({12'h0, ane_o, iso_o, dup_o, spd_o}, 16'h0003);
        wr(16'h0200);
        chk({15'h0, rs_o}, 16'h0000);
        rd(`PBCS_REG_CTRL, 16'h0000, 1'b1);
        wr(16'h017F);
        rd(`PBCS_REG_CTRL, 16'h0100, 1'b1);
        wr(16'h0080);
        tx = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({15'h0, col_o}, 16'h0001);
        wr(16'h0880);
        col = 1'b1;
        rdv = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({9'h0, pd_o, col_o, rdv_o, rxd_o}, 16'h0040);
        rd(`PBCS_REG_CTRL, 16'h0880, 1'b1);
        wr(16'h0000);
        col = 1'b0;
        repeat (2) @(negedge clk_in);
        chk({10'h0, col_o, rdv_o, rxd_o}, 16'h0015);
        // Mid-run reset drops latched fault and jabber; neg enable returns
        flt = 1'b1;
        jab = 1'b1;
        @(negedge clk_in);
        flt = 1'b0;
        jab = 1'b0;
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk({10'h0, ane_o, pd_o, iso_o, rs_o, dup_o, spd_o}, 16'h0022);
        rd(`PBCS_REG_STAT, 16'h7849, 1'b0);
        rd(`PBCS_REG_CTRL, 16'h1100, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
